// ---- verilog/bert_pkg.sv ----
/*
 * Shared constants and types of the TDM bit error rate tester.
 * Assumes a 32-bit AXI4-Lite register bus and byte addresses.
 */
package bert_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CONTROL_ONE   = 8'h00;
	localparam logic [7:0] OFS_IFACE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_PATTERN       = 8'h08;
	localparam logic [7:0] OFS_ALT_REPEAT    = 8'h0c;
	localparam logic [7:0] OFS_TX_SLOTS      = 8'h10;
	localparam logic [7:0] OFS_RX_SLOTS      = 8'h14;
	localparam logic [7:0] OFS_BIT_COUNT     = 8'h18;
	localparam logic [7:0] OFS_ERROR_COUNT   = 8'h1c;
	localparam logic [7:0] OFS_EVENT_INFO    = 8'h20;
	localparam logic [7:0] OFS_CHANGE_STATUS = 8'h24;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_CLEAR     = 0;
	localparam int CTL_MODE_LSB  = 1;
	localparam int CTL_MASK_SYNC = 4;
	localparam int CTL_MASK_ERR  = 5;
	localparam int CTL_MASK_OVF  = 6;
	localparam int IFC_ENABLE    = 0;
	localparam int IFC_DIRECTION = 1;
	localparam int IFC_RX_FBIT   = 2;
	localparam int IFC_TX_FBIT   = 3;
	localparam int EV_SYNC       = 0;
	localparam int EV_ERROR      = 1;
	localparam int EV_OVERFLOW   = 2;
	localparam int ST_SYNC_CHG   = 0;
	localparam int ST_ERROR      = 1;
	localparam int ST_BC_OVF     = 2;
	localparam int ST_EC_OVF     = 3;
	localparam int ST_IN_SYNC    = 4;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [31:0] PATTERN_RESET    = 32'hffffffff;
	localparam logic [7:0]  ALT_REPEAT_RESET = 8'h01;
	localparam logic [4:0]  REP_LEN_RESET    = 5'h1f;
	localparam logic [5:0]  SYNC_RUN         = 6'h20;
	localparam logic [6:0]  LOSS_WINDOW      = 7'h40;
	localparam logic [3:0]  LOSS_ERRORS      = 4'h6;
	localparam logic [3:0]  QRSS_ZERO_LIMIT  = 4'he;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		PAT_PRBS7,
		PAT_PRBS11,
		PAT_PRBS15,
		PAT_QRSS,
		PAT_REPEAT,
		PAT_ALTERNATE,
		PAT_DALY
	} pattern_mode_t;

endpackage

// ---- verilog/bert_pattern_gen.sv ----
/*
 * Pattern source: pseudorandom, repetitive, alternating-word and Daly.
 * Assumes step is a one-cycle pulse per bit; restart reloads from pattern, or from DALY_WORD in Daly mode.
 */
`timescale 1ns/1ps
module bert_pattern_gen
	import bert_pkg::*;
#(
	parameter logic [31:0] DALY_WORD = 32'h000000ff
)
(
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// Control
	input  wire logic          restart,
	input  wire logic          step,
	input  wire logic          seedEn,
	input  wire logic          seedBit,
	input  wire pattern_mode_t mode,
	input  wire logic [31:0]   pattern,
	input  wire logic [7:0]    wordCount,
	input  wire logic [4:0]    repLen,
	// Current bit
	output logic               patBit
);

	typedef struct packed {
		logic [19:0] lfsr;
		logic [31:0] rot;
		logic [3:0]  bitIdx;
		logic [7:0]  wordRep;
		logic        wordSel;
		logic [3:0]  zeroRun;
		logic [4:0]  repIdx;
	} gen_state_t;

	gen_state_t state_q;
	gen_state_t state_d;

	function automatic logic prbsFeedback(input pattern_mode_t m, input logic [19:0] r);
		unique case (m)
			PAT_PRBS7:  return r[6] ^ r[5];
			PAT_PRBS11: return r[10] ^ r[8];
			PAT_PRBS15: return r[14] ^ r[13];
			PAT_QRSS:   return r[19] ^ r[16];
			default:    return 1'b0;
		endcase
	endfunction

	always_comb
	begin
		logic        fb;
		logic [15:0] word;
		logic [4:0]  lastIdx;
		fb = prbsFeedback(mode, state_q.lfsr);
		word = state_q.wordSel ? pattern[31:16] : pattern[15:0];
		lastIdx = (mode == PAT_DALY) ? 5'h1f : repLen;
		state_d = state_q;
		unique case (mode)
			PAT_PRBS7, PAT_PRBS11, PAT_PRBS15: patBit = fb;
			// Long zero runs are forced to a one, as the quasi-random signal needs
			PAT_QRSS:      patBit = fb | (state_q.zeroRun >= QRSS_ZERO_LIMIT);
			PAT_ALTERNATE: patBit = word[state_q.bitIdx];
			default:       patBit = state_q.rot[0];
		endcase
		if (restart)
		begin
			state_d.lfsr = pattern[19:0];
			state_d.rot = (mode == PAT_DALY) ? DALY_WORD : pattern;
			state_d.bitIdx = 4'h0;
			state_d.wordRep = 8'h00;
			state_d.wordSel = 1'b0;
			state_d.zeroRun = 4'h0;
			state_d.repIdx = 5'h00;
		end
		else if (step)
		begin
			state_d.lfsr = {state_q.lfsr[18:0], seedEn ? seedBit : fb};
			state_d.rot = {state_q.rot[0], state_q.rot[31:1]};
			state_d.repIdx = state_q.repIdx + 5'h01;
			// Reload after the programmed length, so short patterns repeat cleanly
			if (state_q.repIdx == lastIdx)
			begin
				state_d.repIdx = 5'h00;
				state_d.rot = (mode == PAT_DALY) ? DALY_WORD : pattern;
			end
			state_d.zeroRun = patBit ? 4'h0 :
				((state_q.zeroRun == 4'hf) ? 4'hf : state_q.zeroRun + 4'h1);
			state_d.bitIdx = state_q.bitIdx + 4'h1;
			if (state_q.bitIdx == 4'hf)
			begin
				// A count of zero wraps to 256 words
				if (8'(state_q.wordRep + 8'h01) == wordCount)
				begin
					state_d.wordRep = 8'h00;
					state_d.wordSel = ~state_q.wordSel;
				end
				else
				begin
					state_d.wordRep = state_q.wordRep + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

endmodule // bert_pattern_gen

// ---- verilog/tdm_bit_error_rate_tester.sv ----
/*
 * Bit error rate tester behind an AXI4-Lite slave, on framer TDM bit streams.
 * Assumes the framer gives one-cycle bit strobes with slot index and F-bit flag.
 */
// How it works
// - Generator and checker offer three pseudorandom lengths, quasi-random and Daly.
// - A repetitive pattern of 1 to 32 bits is sent and checked.
// - Two 16-bit words alternate after 1 to 256 repeats.
// - Receiver keeps a 32-bit bit counter and a 24-bit error counter.
// - Sync change, bit error and overflow events each have a mask bit.
// - An information register tells software which events occurred.
// - A status register records sync changes, errors and overflows.
// - Interface control bit 1 picks network or backplane direction.
// - Slot selectors map the tester into chosen time slots only.
// - In T1, separate enables let the tester use the F-bit.
// - Four pattern bytes form a 32-bit pattern, rightmost bit first.
// - First word from the low two bytes, second from the high two.
// - In sync, the bit counter counts every received bit.
// - In sync, the error counter counts every mismatched bit.
// - Toggling the clear bit clears both counters.
// - Counters saturate and each sets its own status overflow flag; both share one information flag.
// - Each alternating word repeats the programmed count of times.
// - Latched flags set on their event and clear on a host read.
`timescale 1ns/1ps
module tdm_bit_error_rate_tester
	import bert_pkg::*;
#(
	parameter int          BIT_COUNT_W = 32,
	parameter int          ERR_COUNT_W = 24,
	parameter logic [31:0] DALY_WORD   = 32'h000000ff
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transmit stream
	input  wire logic        txBitEn,
	input  wire logic [4:0]  txSlot,
	input  wire logic        txFbit,
	input  wire logic        txDataIn,
	output logic             txDataOut,
	// Receive stream
	input  wire logic        rxBitEn,
	input  wire logic [4:0]  rxSlot,
	input  wire logic        rxFbit,
	input  wire logic        rxData,
	// Mux steering and state
	output logic             testerActive,
	output logic             mapBackplane,
	output logic             rxInSync
);

	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic                   arready;
		logic                   bvalid;
		logic                   rvalid;
		logic [1:0]             bresp;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic [7:0]             awaddr;
		logic                   awHave;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   wHave;
		logic [7:0]             ctl;
		logic [3:0]             iface;
		logic [31:0]            pattern;
		logic [7:0]             altRepeat;
		logic [4:0]             repLen;
		logic [31:0]            txSlots;
		logic [31:0]            rxSlots;
		logic [BIT_COUNT_W-1:0] bitCnt;
		logic [ERR_COUNT_W-1:0] errCnt;
		logic [2:0]             info;
		logic [3:0]             status;
		logic                   inSync;
		logic [5:0]             runCnt;
		logic [6:0]             winCnt;
		logic [3:0]             winErr;
		logic                   clrPrev;
		logic                   restart;
		logic                   txOut;
	} top_state_t;

	top_state_t    state_q;
	top_state_t    state_d;
	pattern_mode_t mode;
	logic          txBit;
	logic          refBit;
	logic          txHit;
	logic          rxHit;
	logic          mismatch;
	logic          clrRise;
	logic          refStep;
	logic          syncEv;
	logic          errEv;
	logic          bcOvfEv;
	logic          ecOvfEv;

	function automatic logic slotHit(input logic en, input logic [31:0] sel,
		input logic [4:0] slot, input logic fbit, input logic fuse);
		return en && (fbit ? fuse : sel[slot]);
	endfunction

	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction

	assign mode = pattern_mode_t'(state_q.ctl[CTL_MODE_LSB +: 3]);

	// ****************************************
	// Pattern sources
	// ****************************************
	bert_pattern_gen #(.DALY_WORD(DALY_WORD)) txGen (
		.mclk      (mclk),
		.rst       (rst),
		.restart   (state_q.restart),
		.step      (txHit),
		.seedEn    (1'b0),
		.seedBit   (1'b0),
		.mode      (mode),
		.pattern   (state_q.pattern),
		.wordCount (state_q.altRepeat),
		.repLen    (state_q.repLen),
		.patBit    (txBit)
	);

	// Out of sync, pseudorandom and quasi-random modes seed from the line; others slip a bit
	bert_pattern_gen #(.DALY_WORD(DALY_WORD)) rxGen (
		.mclk      (mclk),
		.rst       (rst),
		.restart   (state_q.restart),
		.step      (refStep),
		.seedEn    (!state_q.inSync),
		.seedBit   (rxData),
		.mode      (mode),
		.pattern   (state_q.pattern),
		.wordCount (state_q.altRepeat),
		.repLen    (state_q.repLen),
		.patBit    (refBit)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic rdInfo;
		logic rdStatus;
		logic [7:0] wa;
		logic [7:0] ra;
		rdInfo = 1'b0;
		rdStatus = 1'b0;
		wa = {state_q.awaddr[7:2], 2'b00};
		ra = {s_axi_araddr[7:2], 2'b00};
		state_d = state_q;
		state_d.restart = 1'b0;
		syncEv = 1'b0;
		errEv = 1'b0;
		bcOvfEv = 1'b0;
		ecOvfEv = 1'b0;
		txHit = txBitEn && slotHit(state_q.iface[IFC_ENABLE], state_q.txSlots,
			txSlot, txFbit, state_q.iface[IFC_TX_FBIT]);
		rxHit = rxBitEn && slotHit(state_q.iface[IFC_ENABLE], state_q.rxSlots,
			rxSlot, rxFbit, state_q.iface[IFC_RX_FBIT]);
		mismatch = rxData ^ refBit;
		clrRise = state_q.ctl[CTL_CLEAR] && !state_q.clrPrev;
		refStep = rxHit && (state_q.inSync || !mismatch || mode <= PAT_QRSS);
		state_d.clrPrev = state_q.ctl[CTL_CLEAR];
		if (txBitEn)
			state_d.txOut = txHit ? txBit : txDataIn;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && state_q.awready)
		begin
			state_d.awHave = 1'b1;
			state_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_q.wready)
		begin
			state_d.wHave = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			state_d.bvalid = 1'b0;
		if (state_q.awHave && state_q.wHave && !state_q.bvalid)
		begin
			state_d.awHave = 1'b0;
			state_d.wHave = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = RESP_OKAY;
			unique case (wa)
				OFS_CONTROL_ONE:
				begin
					state_d.ctl = 8'(mergeStrb(32'(state_q.ctl), state_q.wdata, state_q.wstrb));
					state_d.restart = 1'b1;
				end
				OFS_IFACE_CONTROL:
					state_d.iface = 4'(mergeStrb(32'(state_q.iface), state_q.wdata,
						state_q.wstrb));
				OFS_PATTERN:
				begin
					state_d.pattern = mergeStrb(state_q.pattern, state_q.wdata,
						state_q.wstrb);
					state_d.restart = 1'b1;
				end
				OFS_ALT_REPEAT:
				begin
					// Bits [12:8] hold the repetitive pattern length less one
					{state_d.repLen, state_d.altRepeat} = 13'(mergeStrb(
						32'({state_q.repLen, state_q.altRepeat}), state_q.wdata,
						state_q.wstrb));
					state_d.restart = 1'b1;
				end
				OFS_TX_SLOTS:
					state_d.txSlots = mergeStrb(state_q.txSlots, state_q.wdata, state_q.wstrb);
				OFS_RX_SLOTS:
					state_d.rxSlots = mergeStrb(state_q.rxSlots, state_q.wdata, state_q.wstrb);
				OFS_BIT_COUNT, OFS_ERROR_COUNT, OFS_EVENT_INFO, OFS_CHANGE_STATUS: ;
				default:
					state_d.bresp = RESP_SLVERR;
			endcase
		end

		// Read channel: data one cycle after the address
		if (s_axi_rvalid && s_axi_rready)
			state_d.rvalid = 1'b0;
		if (s_axi_arvalid && state_q.arready)
		begin
			state_d.rvalid = 1'b1;
			state_d.rresp = RESP_OKAY;
			state_d.rdata = 32'h00000000;
			unique case (ra)
				OFS_CONTROL_ONE:   state_d.rdata = 32'(state_q.ctl);
				OFS_IFACE_CONTROL: state_d.rdata = 32'(state_q.iface);
				OFS_PATTERN:       state_d.rdata = state_q.pattern;
				OFS_ALT_REPEAT:    state_d.rdata = 32'({state_q.repLen, state_q.altRepeat});
				OFS_TX_SLOTS:      state_d.rdata = state_q.txSlots;
				OFS_RX_SLOTS:      state_d.rdata = state_q.rxSlots;
				OFS_BIT_COUNT:     state_d.rdata = 32'(state_q.bitCnt);
				OFS_ERROR_COUNT:   state_d.rdata = 32'(state_q.errCnt);
				OFS_EVENT_INFO:
				begin
					state_d.rdata = 32'(state_q.info);
					rdInfo = 1'b1;
				end
				OFS_CHANGE_STATUS:
				begin
					state_d.rdata = 32'({state_q.inSync, state_q.status});
					rdStatus = 1'b1;
				end
				default:           state_d.rresp = RESP_SLVERR;
			endcase
		end

		// ****************************************
		// Receive synchronizer and counters
		// ****************************************
		if (state_q.restart)
		begin
			syncEv = state_q.inSync;
			state_d.inSync = 1'b0;
			state_d.runCnt = 6'h00;
		end
		else if (rxHit && !state_q.inSync)
		begin
			if (mismatch)
				state_d.runCnt = 6'h00;
			else if (state_q.runCnt == SYNC_RUN - 6'h01)
			begin
				state_d.inSync = 1'b1;
				syncEv = 1'b1;
				state_d.runCnt = 6'h00;
				state_d.winCnt = 7'h00;
				state_d.winErr = 4'h0;
			end
			else
				state_d.runCnt = state_q.runCnt + 6'h01;
		end
		else if (rxHit)
		begin
			if (!(&state_q.bitCnt))
			begin
				state_d.bitCnt = state_q.bitCnt + 1'b1;
				bcOvfEv = &state_d.bitCnt;
			end
			if (mismatch)
			begin
				errEv = 1'b1;
				state_d.winErr = state_q.winErr + 4'h1;
				if (!(&state_q.errCnt))
				begin
					state_d.errCnt = state_q.errCnt + 1'b1;
					ecOvfEv = &state_d.errCnt;
				end
			end
			// Error density judged over a fixed window of checked bits
			state_d.winCnt = state_q.winCnt + 7'h01;
			if (state_d.winErr >= LOSS_ERRORS)
			begin
				state_d.inSync = 1'b0;
				syncEv = 1'b1;
			end
			if (state_q.winCnt == LOSS_WINDOW - 7'h01)
			begin
				state_d.winCnt = 7'h00;
				state_d.winErr = 4'h0;
			end
		end
		if (clrRise)
		begin
			state_d.bitCnt = '0;
			state_d.errCnt = '0;
		end

		// Set wins over the clear of a read
		state_d.info = (rdInfo ? 3'h0 : state_q.info) | {
			(bcOvfEv | ecOvfEv) & !state_q.ctl[CTL_MASK_OVF],
			errEv & !state_q.ctl[CTL_MASK_ERR],
			syncEv & !state_q.ctl[CTL_MASK_SYNC]};
		state_d.status = (rdStatus ? 4'h0 : state_q.status) |
			{ecOvfEv, bcOvfEv, errEv, syncEv};

		state_d.awready = !state_d.awHave && !state_d.bvalid;
		state_d.wready = !state_d.wHave && !state_d.bvalid;
		state_d.arready = !state_d.rvalid;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_q <= '0;
			state_q.pattern <= PATTERN_RESET;
			state_q.altRepeat <= ALT_REPEAT_RESET;
			state_q.repLen <= REP_LEN_RESET;
		end
		else
			state_q <= state_d;
	end

	assign s_axi_awready = state_q.awready;
	assign s_axi_wready = state_q.wready;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_arready = state_q.arready;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
	assign s_axi_rvalid = state_q.rvalid;
	assign txDataOut = state_q.txOut;
	assign testerActive = state_q.iface[IFC_ENABLE];
	assign mapBackplane = state_q.iface[IFC_DIRECTION];
	assign rxInSync = state_q.inSync;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence clearToggle;
		!state_q.ctl[CTL_CLEAR] ##1 state_q.ctl[CTL_CLEAR];
	endsequence

	a_clear_counters: assert property (clearToggle |=>
		state_q.bitCnt == '0 && state_q.errCnt == '0)
		else $error("counters not cleared after clear toggle");
	a_clear_once: assert property (clrRise |=> !clrRise)
		else $error("clear edge seen twice");
	a_bit_count: assert property (
		(state_q.inSync && rxHit && !state_q.restart && !clrRise && !(&state_q.bitCnt))
		|=> state_q.bitCnt == $past(state_q.bitCnt) + 1'b1)
		else $error("bit counter missed a received bit");
	a_err_count: assert property (
		(state_q.inSync && rxHit && mismatch && !state_q.restart && !clrRise
		&& !(&state_q.errCnt)) |=> state_q.errCnt == $past(state_q.errCnt) + 1'b1)
		else $error("error counter missed an errored bit");
	a_bit_saturate: assert property ((&state_q.bitCnt && !clrRise) |=> &state_q.bitCnt)
		else $error("bit counter wrapped");
	a_err_overflow: assert property ($rose(&state_q.errCnt) |-> state_q.status[ST_EC_OVF])
		else $error("error overflow flag not set");
	a_sync_entry: assert property ($rose(state_q.inSync) |->
		$past(state_q.runCnt) == SYNC_RUN - 6'h01 && $past(rxHit))
		else $error("sync declared without full matching run");
	a_sync_status: assert property ($changed(state_q.inSync) |-> state_q.status[ST_SYNC_CHG])
		else $error("sync change not recorded");
	a_sync_mask: assert property ((syncEv && !state_q.ctl[CTL_MASK_SYNC]) |=>
		state_q.info[EV_SYNC])
		else $error("unmasked sync event lost");
	a_tx_bypass: assert property ((txBitEn && !txHit) |=> txDataOut == $past(txDataIn))
		else $error("unselected slot altered");
	a_fbit_block: assert property (
		(txBitEn && txFbit && !state_q.iface[IFC_TX_FBIT]) |=> txDataOut == $past(txDataIn))
		else $error("F-bit used while disabled");

endmodule // tdm_bit_error_rate_tester

// ---- test/framer_stream_model.sv ----
/*
 * Framer side of the tester: T1 frame timing, tx and rx bit strobes, rx looped from tx.
 * Assumes one clock; the bench drives run and flip by non-blocking assignment.
 */
`timescale 1ns/1ps
module framer_stream_model
#(
	parameter int GAP   = 5,
	parameter int SLOTS = 24
)
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Bench control
	input  wire logic       run,
	input  wire logic       flip,
	// Transmit stream
	output logic            txBitEn,
	output logic [4:0]      txSlot,
	output logic            txFbit,
	output logic            txDataIn,
	input  wire logic       txDataOut,
	// Receive stream
	output logic            rxBitEn,
	output logic [4:0]      rxSlot,
	output logic            rxFbit,
	output logic            rxData
);
	// ****************************************
	// Frame timing and loopback
	// ****************************************
	int         div;
	int         pos;
	logic [4:0] slot;

	assign slot = (pos == 0) ? 5'h00 : 5'((pos - 1) / 8);

	always_ff @(posedge mclk)
	begin
		txBitEn  <= 1'b0;
		rxBitEn  <= 1'b0;
		// Idle lines move every cycle so a stale bit never passes for data
		txDataIn <= ~txDataIn;
		rxData   <= ~rxData;
		if (rst)
		begin
			div      <= 0;
			pos      <= 0;
			txSlot   <= 5'h00;
			rxSlot   <= 5'h00;
			txFbit   <= 1'b0;
			rxFbit   <= 1'b0;
			txDataIn <= 1'b0;
			rxData   <= 1'b0;
		end
		else if (run || div != 0)
		begin
			div <= (div == GAP - 1) ? 0 : div + 1;
			if (div == 0)
			begin
				txBitEn <= 1'b1;
				txSlot  <= slot;
				txFbit  <= (pos == 0);
				pos     <= (pos == SLOTS * 8) ? 0 : pos + 1;
			end
			// Two cycles later the tester output of that same bit has settled
			if (div == 2)
			begin
				rxBitEn <= 1'b1;
				rxSlot  <= txSlot;
				rxFbit  <= txFbit;
				rxData  <= txDataOut ^ flip;
			end
		end
	end
endmodule // framer_stream_model

// ---- test/tdm_bit_error_rate_tester_tb_top.sv ----
/*
 * Self-checking bench of the tester: AXI4-Lite host tasks and one task per scenario.
 * Assumes the framer model loops tx back to rx with zero bit lag.
 */
`timescale 1ns/1ps
module tdm_bit_error_rate_tester_tb_top
	import bert_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic        awValid = 1'b0;
	logic        wValid = 1'b0;
	logic        arValid = 1'b0;
	logic        run = 1'b0;
	logic        flip = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp, wResp, rsp;
	logic [31:0] rData, rdVal;
	logic        txBitEn, txFbit, txDataIn, txDataOut, rxBitEn, rxFbit, rxData;
	logic [4:0]  txSlot, rxSlot;
	logic        testerActive, mapBackplane, rxInSync;
	int          failCount = 0;
	int          comparisons = 0;
	int          rxSeen = 0;
	int          fSeen = 0;

	always #5 mclk = ~mclk;

	always @(posedge mclk)
	begin
		if (rxBitEn === 1'b1)
			rxSeen++;
		if (rxBitEn === 1'b1 && rxFbit === 1'b1)
			fSeen++;
	end

	// Narrow error counter, so that saturation is reachable in a short run
	tdm_bit_error_rate_tester #(.ERR_COUNT_W(4)) i_dut (
		.mclk(mclk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(1'b1), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(1'b1),
		.txBitEn(txBitEn), .txSlot(txSlot), .txFbit(txFbit), .txDataIn(txDataIn),
		.txDataOut(txDataOut), .rxBitEn(rxBitEn), .rxSlot(rxSlot), .rxFbit(rxFbit),
		.rxData(rxData), .testerActive(testerActive), .mapBackplane(mapBackplane),
		.rxInSync(rxInSync)
	);

	framer_stream_model i_framer (
		.mclk(mclk), .rst(rst), .run(run), .flip(flip),
		.txBitEn(txBitEn), .txSlot(txSlot), .txFbit(txFbit), .txDataIn(txDataIn),
		.txDataOut(txDataOut), .rxBitEn(rxBitEn), .rxSlot(rxSlot), .rxFbit(rxFbit),
		.rxData(rxData)
	);

	// ****************************************
	// Host bus, compare and closing tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Ready lines are held high, so each answer is taken where it is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awAddr  <= a;
		wData   <= d;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (awReady === 1'b1)
				aw = 1'b1;
			if (wReady === 1'b1)
				w = 1'b1;
			if (aw)
				awValid <= 1'b0;
			if (w)
				wValid <= 1'b0;
		end
		do
			@(posedge mclk);
		while (bValid !== 1'b1);
		wResp = bResp;
	endtask

	task automatic rd(input logic [7:0] a);
		arAddr  <= a;
		arValid <= 1'b1;
		do
			@(posedge mclk);
		while (arReady !== 1'b1);
		arValid <= 1'b0;
		do
			@(posedge mclk);
		while (rValid !== 1'b1);
		rdVal = rData;
		rsp = rResp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdVal, e);
	endtask

	task automatic wait_sync();
		int n;
		n = 0;
		repeat (2) @(posedge mclk);
		while (rxInSync !== 1'b1 && n < 3000)
		begin
			@(posedge mclk);
			n++;
		end
		chk(32'(rxInSync), 32'h1);
	endtask

	task automatic wait_rx();
		do
			@(posedge mclk);
		while (rxBitEn !== 1'b1);
	endtask

	task automatic tally_and_finish();
		if (failCount == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Kind 0 expects no counting, 1 only F-bits, 2 every received bit
	task automatic count_check(input int kind);
		logic [31:0] a;
		int          s0;
		int          f0;
		run <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(OFS_BIT_COUNT);
		a = rdVal;
		s0 = rxSeen;
		f0 = fSeen;
		run <= 1'b1;
		repeat (2000) @(posedge mclk);
		run <= 1'b0;
		repeat (20) @(posedge mclk);
		rd(OFS_BIT_COUNT);
		chk(rdVal - a, kind == 2 ? 32'(rxSeen - s0) : kind == 1 ? 32'(fSeen - f0) : 32'h0);
		run <= 1'b1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rc(OFS_PATTERN, PATTERN_RESET);
		rc(OFS_ALT_REPEAT, {19'h0, REP_LEN_RESET, ALT_REPEAT_RESET});
		wr(OFS_BIT_COUNT, 32'h5);
		rc(OFS_BIT_COUNT, 32'h0);
		wr(8'h28, 32'h1);
		chk(32'(wResp), 32'(RESP_SLVERR));
		rc(8'h28, 32'h0);
		chk(32'(rsp), 32'(RESP_SLVERR));
	endtask

	task automatic t_modes();
		wr(OFS_IFACE_CONTROL, 32'hf);
		chk(32'(mapBackplane), 32'h1);
		chk(32'(testerActive), 32'h1);
		wr(OFS_PATTERN, 32'hffffffff);
		wr(OFS_TX_SLOTS, 32'hffffffff);
		wr(OFS_RX_SLOTS, 32'hffffffff);
		run <= 1'b1;
		for (int m = 0; m < 7; m++)
		begin
			wr(OFS_CONTROL_ONE, 32'(m) << CTL_MODE_LSB);
			wait_sync();
		end
	endtask

	task automatic t_status();
		logic [39:0] s;
		wr(OFS_PATTERN, 32'h5ad6b5ad);
		wr(OFS_ALT_REPEAT, 32'h401);
		wr(OFS_CONTROL_ONE, 32'h8);
		rd(OFS_CHANGE_STATUS);
		rd(OFS_EVENT_INFO);
		wait_sync();
		rc(OFS_CHANGE_STATUS, 32'h11);
		rc(OFS_CHANGE_STATUS, 32'h10);
		rc(OFS_EVENT_INFO, 32'h1);
		rc(OFS_EVENT_INFO, 32'h0);
		for (int i = 0; i < 40; i++)
		begin
			do
				@(posedge mclk);
			while (txBitEn !== 1'b1);
			@(posedge mclk);
			s[i] = txDataOut;
		end
		chk(32'(s[34:0]), 32'(s[39:5]));
		chk(32'($countones(s[4:0])), 32'h3);
		wr(OFS_CONTROL_ONE, 32'h18);
		rd(OFS_CHANGE_STATUS);
		rd(OFS_EVENT_INFO);
		wait_sync();
		rc(OFS_EVENT_INFO, 32'h0);
		rc(OFS_CHANGE_STATUS, 32'h11);
	endtask

	// Errors spaced too far apart to lose sync, until the counter saturates
	task automatic t_errors();
		for (int i = 0; i < 15; i++)
		begin
			wait_rx();
			flip <= 1'b1;
			wait_rx();
			flip <= 1'b0;
			repeat (75) @(posedge mclk);
			if (i == 0)
				rc(OFS_ERROR_COUNT, 32'h1);
		end
		rc(OFS_ERROR_COUNT, 32'hf);
		rc(OFS_CHANGE_STATUS, 32'h1a);
		rc(OFS_EVENT_INFO, 32'h6);
		count_check(2);
	endtask

	task automatic t_mapping();
		logic d;
		run <= 1'b0;
		wr(OFS_TX_SLOTS, 32'h0);
		wr(OFS_RX_SLOTS, 32'h0);
		wr(OFS_IFACE_CONTROL, 32'h1);
		chk(32'(mapBackplane), 32'h0);
		count_check(0);
		for (int i = 0; i < 8; i++)
		begin
			do
				@(posedge mclk);
			while (txBitEn !== 1'b1);
			d = txDataIn;
			@(posedge mclk);
			chk(32'(txDataOut), 32'(d));
		end
		// No bit may straddle the change of selection
		run <= 1'b0;
		wr(OFS_IFACE_CONTROL, 32'hd);
		count_check(1);
	endtask

	task automatic t_clear();
		run <= 1'b0;
		wr(OFS_CONTROL_ONE, 32'h19);
		rc(OFS_BIT_COUNT, 32'h0);
		rc(OFS_ERROR_COUNT, 32'h0);
	endtask

	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_modes();
		t_status();
		t_errors();
		t_mapping();
		t_clear();
		tally_and_finish();
	end

	// Whole run takes well under half of this span
	initial
	begin
		repeat (60000) @(posedge mclk);
		failCount++;
		tally_and_finish();
	end
endmodule // tdm_bit_error_rate_tester_tb_top
